// File: hw/txw_params.svh
// Notes on behaviour
// - ownership bit set means controller owns
// - controller clears ownership when done
// - error summary ORs the six error bits
// - jabber expiry: flag, interrupt, abort, stop
// - heartbeat fail invalid when jabber set
// - carrier lost mid frame sets loss flag
// - carrier never present sets no-carrier flag
// - carrier flags invalid in internal loopback
// - collision after 64 bytes aborts, late flag
// - late collision invalid when underflow set
// - fifo underrun: flag, abort, suspend, interrupts
// - sixteen collisions abort with excessive flag
`ifndef TXW_PARAMS_SVH
`define TXW_PARAMS_SVH

// ----------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------
`define TXW_BIT_OWN      31
`define TXW_BIT_ES       15
`define TXW_BIT_TO       14
`define TXW_BIT_LO       11
`define TXW_BIT_NC       10
`define TXW_BIT_LC       9
`define TXW_BIT_EC       8
`define TXW_BIT_HF       7
`define TXW_CC_LO        3
`define TXW_CC_HI        6
`define TXW_BIT_UF       1

// ----------------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------------
`define TXW_OFS_MODE     8'h00
`define TXW_OFS_STATUS   8'h04
`define TXW_OFS_MASK     8'h08
`define TXW_OFS_DESC     8'h0c
`define TXW_OFS_POLL     8'h10
`define TXW_MODE_RUN     1
`define TXW_LB_LO        10
`define TXW_LB_HI        11
`define TXW_LB_INTERNAL  2'h1
`define TXW_STS_W        6
`define TXW_STS_TX       0
`define TXW_STS_JAB      3
`define TXW_STS_UNF      5
`define TXW_STS_IMPL     6'h29
`define TXW_STATE_LO     20
`define TXW_STATE_W      3
`define TXW_ALIGN_MASK   32'hffff_fffc
`define TXW_DESC_STRIDE  32'h0000_0010
`define TXW_RESP_OKAY    2'h0
`define TXW_RESP_SLVERR  2'h2

// ----------------------------------------------------------------------
// frame limits
// ----------------------------------------------------------------------
`define TXW_WIN_BYTES    7'h40
`define TXW_COLL_LAST    4'hf

`endif

// File: hw/txw_pkg.sv
package txw_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_FETCH,
    S_SEND,
    S_WRITE,
    S_STOPPED,
    S_SUSPENDED
  } txw_fsm_e;

  typedef struct packed {
    txw_fsm_e    st;
    txw_fsm_e    after;
    logic        cont;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        tx_go;
    logic        tx_abort;
    logic [31:0] desc_addr;
    logic        run;
    logic [1:0]  loop;
    logic        poll;
    logic [5:0]  sts;
    logic [5:0]  mask;
    logic        irq;
    logic        uf;
    logic        ec;
    logic        lc;
    logic        lo;
    logic        to;
    logic        hf;
    logic        seen;
    logic [3:0]  ccnt;
    logic [6:0]  bytes;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } txw_regs_s;

endpackage

// File: hw/txw_status_word.sv
`timescale 1ns/1ps
`default_nettype none
`include "txw_params.svh"

module txw_status_word (
  // frame flags
  input  wire logic        i_uf,
  input  wire logic        i_ec,
  input  wire logic        i_lc,
  input  wire logic        i_nc,
  input  wire logic        i_lo,
  input  wire logic        i_to,
  input  wire logic        i_hf,
  input  wire logic [3:0]  i_ccnt,
  input  wire logic [1:0]  i_loop,
  // composed status word
  output logic      [31:0] o_word
);

  logic internal_lb;
  logic lo_valid;
  logic nc_valid;
  logic lc_valid;
  logic hf_valid;

  assign internal_lb = (i_loop == `TXW_LB_INTERNAL);
  assign lo_valid    = i_lo && !internal_lb;
  assign nc_valid    = i_nc && !internal_lb;
  assign lc_valid    = i_lc && !i_uf;
  assign hf_valid    = i_hf && !i_to && !i_uf;

  always_comb begin
    o_word                              = '0;
    o_word[`TXW_BIT_OWN]                = 1'b0;
    o_word[`TXW_BIT_TO]                 = i_to;
    o_word[`TXW_BIT_LO]                 = lo_valid;
    o_word[`TXW_BIT_NC]                 = nc_valid;
    o_word[`TXW_BIT_LC]                 = lc_valid;
    o_word[`TXW_BIT_EC]                 = i_ec;
    o_word[`TXW_BIT_HF]                 = hf_valid;
    o_word[`TXW_CC_HI:`TXW_CC_LO]       = i_ccnt;
    o_word[`TXW_BIT_UF]                 = i_uf;
    o_word[`TXW_BIT_ES]                 = i_uf || i_ec || lc_valid || nc_valid || lo_valid || i_to;
  end

endmodule

`default_nettype wire

// File: hw/txw_writeback.sv
`timescale 1ns/1ps
`default_nettype none
`include "txw_params.svh"

module txw_writeback #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // axi4-lite slave
  input  wire logic              i_s_awvalid,
  output logic                   o_s_awready,
  input  wire logic [ADDR_W-1:0] i_s_awaddr,
  input  wire logic              i_s_wvalid,
  output logic                   o_s_wready,
  input  wire logic [31:0]       i_s_wdata,
  input  wire logic [3:0]        i_s_wstrb,
  output logic                   o_s_bvalid,
  input  wire logic              i_s_bready,
  output logic      [1:0]        o_s_bresp,
  input  wire logic              i_s_arvalid,
  output logic                   o_s_arready,
  input  wire logic [ADDR_W-1:0] i_s_araddr,
  output logic                   o_s_rvalid,
  input  wire logic              i_s_rready,
  output logic      [31:0]       o_s_rdata,
  output logic      [1:0]        o_s_rresp,
  // interrupt
  output logic                   o_irq,
  // descriptor memory master
  output logic                   o_mem_req,
  output logic                   o_mem_we,
  output logic      [31:0]       o_mem_addr,
  output logic      [31:0]       o_mem_wdata,
  input  wire logic              i_mem_ack,
  input  wire logic [31:0]       i_mem_rdata,
  // transmitter control
  output logic                   o_tx_go,
  output logic                   o_tx_abort,
  // transmitter events
  input  wire logic              i_byte_sent,
  input  wire logic              i_collision,
  input  wire logic              i_carrier,
  input  wire logic              i_jabber_expire,
  input  wire logic              i_fifo_empty,
  input  wire logic              i_heartbeat_fail,
  input  wire logic              i_buf_done,
  input  wire logic              i_frame_end
);

  txw_pkg::txw_regs_s r;
  txw_pkg::txw_regs_s next_r;
  logic [31:0]        word;
  logic [5:0]         sts_set;
  logic [5:0]         sts_clr;
  logic [7:0]         aw_idx;
  logic [7:0]         ar_idx;

  // ----------------------------------------------------------------------
  // status word composer
  // ----------------------------------------------------------------------
  txw_status_word u_word (
    .i_uf   (r.uf),
    .i_ec   (r.ec),
    .i_lc   (r.lc),
    .i_nc   (!r.seen),
    .i_lo   (r.lo),
    .i_to   (r.to),
    .i_hf   (r.hf),
    .i_ccnt (r.ccnt),
    .i_loop (r.loop),
    .o_word (word)
  );

  assign aw_idx = 8'(r.aw_addr);
  assign ar_idx = 8'(i_s_araddr);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.tx_abort = 1'b0;
    sts_set         = '0;
    sts_clr         = '0;

    // register write side
    if (i_s_awvalid && r.awready) begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = 8'(i_s_awaddr);
    end
    if (i_s_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = i_s_wdata;
      next_r.wstrb = i_s_wstrb;
    end
    if (r.bvalid && i_s_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = `TXW_RESP_OKAY;
      case (aw_idx)
        `TXW_OFS_MODE: begin
          if (r.wstrb[0]) begin
            next_r.run = r.wdata[`TXW_MODE_RUN];
          end
          if (r.wstrb[1]) begin
            next_r.loop = r.wdata[`TXW_LB_HI:`TXW_LB_LO];
          end
        end
        `TXW_OFS_STATUS: begin
          if (r.wstrb[0]) begin
            sts_clr = r.wdata[`TXW_STS_W-1:0];
          end
        end
        `TXW_OFS_MASK: begin
          if (r.wstrb[0]) begin
            next_r.mask = r.wdata[`TXW_STS_W-1:0] & `TXW_STS_IMPL;
          end
        end
        `TXW_OFS_DESC: begin
          next_r.desc_addr = merge(r.desc_addr, r.wdata, r.wstrb) & `TXW_ALIGN_MASK;
        end
        `TXW_OFS_POLL: begin
          next_r.poll = 1'b1;
        end
        default: begin
          next_r.bresp = `TXW_RESP_SLVERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_got;
    next_r.wready  = !next_r.w_got;

    // register read side
    if (r.rvalid && i_s_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (r.arready && i_s_arvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = `TXW_RESP_OKAY;
      next_r.rdata  = '0;
      case (ar_idx)
        `TXW_OFS_MODE: begin
          next_r.rdata[`TXW_MODE_RUN]          = r.run;
          next_r.rdata[`TXW_LB_HI:`TXW_LB_LO]  = r.loop;
        end
        `TXW_OFS_STATUS: begin
          next_r.rdata[`TXW_STS_W-1:0]                 = r.sts;
          next_r.rdata[`TXW_STATE_LO +: `TXW_STATE_W]  = r.st;
        end
        `TXW_OFS_MASK: next_r.rdata[`TXW_STS_W-1:0] = r.mask;
        `TXW_OFS_DESC: next_r.rdata = r.desc_addr;
        `TXW_OFS_POLL: next_r.rdata = '0;
        default:       next_r.rresp = `TXW_RESP_SLVERR;
      endcase
    end
    next_r.arready = !next_r.rvalid;

    // descriptor and frame engine
    unique case (r.st)
      txw_pkg::S_IDLE: begin
        next_r.poll = 1'b0;
        if (r.run) begin
          next_r.st = txw_pkg::S_FETCH;
        end
      end
      txw_pkg::S_SUSPENDED: begin
        if (r.poll && r.run) begin
          next_r.poll = 1'b0;
          next_r.st   = txw_pkg::S_FETCH;
        end else if (!r.run) begin
          next_r.st = txw_pkg::S_IDLE;
        end
      end
      txw_pkg::S_STOPPED: begin
        if (!r.run) begin
          next_r.st = txw_pkg::S_IDLE;
        end
      end
      txw_pkg::S_FETCH: begin
        if (!r.mem_req) begin
          next_r.mem_req  = 1'b1;
          next_r.mem_we   = 1'b0;
          next_r.mem_addr = r.desc_addr;
        end else if (i_mem_ack) begin
          next_r.mem_req = 1'b0;
          if (i_mem_rdata[`TXW_BIT_OWN]) begin
            next_r.st    = txw_pkg::S_SEND;
            next_r.tx_go = 1'b1;
            if (!r.cont) begin
              next_r.uf    = 1'b0;
              next_r.ec    = 1'b0;
              next_r.lc    = 1'b0;
              next_r.lo    = 1'b0;
              next_r.to    = 1'b0;
              next_r.hf    = 1'b0;
              next_r.seen  = 1'b0;
              next_r.ccnt  = '0;
              next_r.bytes = '0;
            end
          end else begin
            next_r.st = txw_pkg::S_SUSPENDED;
          end
        end
      end
      txw_pkg::S_SEND: begin
        if (i_carrier) begin
          next_r.seen = 1'b1;
        end else if (r.seen) begin
          next_r.lo = 1'b1;
        end
        if (i_heartbeat_fail) begin
          next_r.hf = 1'b1;
        end
        if (i_byte_sent && r.bytes != `TXW_WIN_BYTES) begin
          next_r.bytes = r.bytes + 7'h01;
        end
        if (i_jabber_expire) begin
          next_r.to                 = 1'b1;
          sts_set[`TXW_STS_JAB]     = 1'b1;
          next_r.after              = txw_pkg::S_STOPPED;
        end else if (i_fifo_empty) begin
          next_r.uf                 = 1'b1;
          sts_set[`TXW_STS_UNF]     = 1'b1;
          sts_set[`TXW_STS_TX]      = 1'b1;
          next_r.after              = txw_pkg::S_SUSPENDED;
        end else if (i_collision && r.bytes >= `TXW_WIN_BYTES) begin
          next_r.lc                 = 1'b1;
          next_r.after              = txw_pkg::S_IDLE;
        end else if (i_collision && r.ccnt == `TXW_COLL_LAST) begin
          next_r.ec                 = 1'b1;
          next_r.after              = txw_pkg::S_IDLE;
        end else if (i_collision) begin
          // retry: restart the window and clear the heartbeat flag so it is rechecked
          next_r.ccnt  = r.ccnt + 4'h1;
          next_r.bytes = '0;
          next_r.hf    = 1'b0;
        end else if (i_frame_end) begin
          sts_set[`TXW_STS_TX] = 1'b1;
          next_r.after         = txw_pkg::S_IDLE;
          next_r.cont          = 1'b0;
          next_r.tx_go         = 1'b0;
          next_r.st            = txw_pkg::S_WRITE;
        end else if (i_buf_done) begin
          next_r.after = txw_pkg::S_FETCH;
          next_r.cont  = 1'b1;
          next_r.tx_go = 1'b0;
          next_r.st    = txw_pkg::S_WRITE;
        end
        if (i_jabber_expire || i_fifo_empty ||
            (i_collision && (r.bytes >= `TXW_WIN_BYTES || r.ccnt == `TXW_COLL_LAST))) begin
          next_r.tx_abort = 1'b1;
          next_r.tx_go    = 1'b0;
          next_r.cont     = 1'b0;
          next_r.st       = txw_pkg::S_WRITE;
        end
      end
      txw_pkg::S_WRITE: begin
        if (!r.mem_req) begin
          // one store carries every status bit and the ownership release
          next_r.mem_req   = 1'b1;
          next_r.mem_we    = 1'b1;
          next_r.mem_addr  = r.desc_addr;
          next_r.mem_wdata = word;
        end else if (i_mem_ack) begin
          next_r.mem_req   = 1'b0;
          next_r.mem_we    = 1'b0;
          next_r.desc_addr = r.desc_addr + `TXW_DESC_STRIDE;
          next_r.st        = r.after;
        end
      end
      default: next_r.st = txw_pkg::S_IDLE;
    endcase

    // sticky status: a hardware set beats a same-cycle clear
    next_r.sts = (r.sts & ~sts_clr) | sts_set;
    next_r.irq = |(next_r.sts & next_r.mask);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r       <= '0;
      r.st    <= txw_pkg::S_IDLE;
      r.after <= txw_pkg::S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign o_s_awready = r.awready;
  assign o_s_wready  = r.wready;
  assign o_s_bvalid  = r.bvalid;
  assign o_s_bresp   = r.bresp;
  assign o_s_arready = r.arready;
  assign o_s_rvalid  = r.rvalid;
  assign o_s_rdata   = r.rdata;
  assign o_s_rresp   = r.rresp;
  assign o_irq       = r.irq;
  assign o_mem_req   = r.mem_req;
  assign o_mem_we    = r.mem_we;
  assign o_mem_addr  = r.mem_addr;
  assign o_mem_wdata = r.mem_wdata;
  assign o_tx_go     = r.tx_go;
  assign o_tx_abort  = r.tx_abort;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic in_send;
  assign in_send = (r.st == txw_pkg::S_SEND);

  sequence wb_write;
    o_mem_req && o_mem_we;
  endsequence

  sequence wb_start;
    $rose(o_mem_req) && o_mem_we;
  endsequence

  sequence aborted;
    o_tx_abort && !o_tx_go && r.st == txw_pkg::S_WRITE;
  endsequence

  own_return_a: assert property (wb_write |-> !o_mem_wdata[`TXW_BIT_OWN])
    else $error("writeback kept ownership");
  summary_or_a: assert property (wb_write |-> o_mem_wdata[`TXW_BIT_ES] ==
      (o_mem_wdata[`TXW_BIT_UF] | o_mem_wdata[`TXW_BIT_EC] | o_mem_wdata[`TXW_BIT_LC] |
       o_mem_wdata[`TXW_BIT_NC] | o_mem_wdata[`TXW_BIT_LO] | o_mem_wdata[`TXW_BIT_TO]))
    else $error("error summary mismatch");
  hb_jabber_a: assert property ((wb_write and o_mem_wdata[`TXW_BIT_TO]) |-> !o_mem_wdata[`TXW_BIT_HF])
    else $error("heartbeat shown with jabber");
  lb_carrier_a: assert property ((wb_start and $past(r.loop) == `TXW_LB_INTERNAL)
      |-> !o_mem_wdata[`TXW_BIT_LO] && !o_mem_wdata[`TXW_BIT_NC])
    else $error("carrier flag in internal loopback");
  lc_underflow_a: assert property ((wb_write and o_mem_wdata[`TXW_BIT_UF]) |-> !o_mem_wdata[`TXW_BIT_LC])
    else $error("late collision shown with underflow");
  jabber_stop_a: assert property (in_send && i_jabber_expire
      |=> aborted and r.sts[`TXW_STS_JAB] ##1 (wb_write and o_mem_wdata[`TXW_BIT_TO]))
    else $error("jabber not handled");
  underflow_flags_a: assert property (in_send && !i_jabber_expire && i_fifo_empty
      |=> aborted and r.sts[`TXW_STS_UNF] && r.sts[`TXW_STS_TX] && r.after == txw_pkg::S_SUSPENDED)
    else $error("underflow not handled");
  late_coll_a: assert property (in_send && !i_jabber_expire && !i_fifo_empty && i_collision &&
      r.bytes >= `TXW_WIN_BYTES |=> aborted ##1 (wb_write and o_mem_wdata[`TXW_BIT_LC]))
    else $error("late collision not reported");
  excess_coll_a: assert property (in_send && !i_jabber_expire && !i_fifo_empty && i_collision &&
      r.bytes < `TXW_WIN_BYTES && r.ccnt == `TXW_COLL_LAST |=> aborted ##1 (wb_write and o_mem_wdata[`TXW_BIT_EC]))
    else $error("excessive collisions not reported");
  host_owned_a: assert property (r.st == txw_pkg::S_FETCH && o_mem_req && i_mem_ack && !i_mem_rdata[`TXW_BIT_OWN]
      |=> !o_tx_go && r.st == txw_pkg::S_SUSPENDED)
    else $error("host owned descriptor processed");
  carrier_loss_a: assert property (in_send && r.seen && !i_carrier |=> r.lo)
    else $error("carrier loss missed");
  no_carrier_a: assert property ((wb_start and !$past(r.seen) && $past(r.loop) != `TXW_LB_INTERNAL)
      |-> o_mem_wdata[`TXW_BIT_NC])
    else $error("no carrier missed");

endmodule

`default_nettype wire

// File: tb/txw_host_mem.sv
`timescale 1ns/1ps
`default_nettype none

module txw_host_mem (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // descriptor bus
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic      [31:0] o_rdata
);
  // ----------------------------------------------------------------
  // descriptor store, one slot per 16-byte descriptor
  // ----------------------------------------------------------------
  logic [31:0] mem [16];
  logic [3:0]  cnt;

  // read data is inverted every cycle outside the ack cycle so stale values do not hold steady
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0;
      cnt     <= 4'h0;
    end else if (i_req && !o_ack && cnt >= (i_slow ? 4'h5 : 4'h0)) begin
      o_ack <= 1'b1;
      cnt   <= 4'h0;
      if (i_we) begin
        mem[i_addr[7:4]] <= i_wdata;
      end else begin
        o_rdata <= mem[i_addr[7:4]];
      end
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt     <= i_req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

`default_nettype wire

// File: tb/tx_descriptor_status_writeback_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "txw_params.svh"

module tx_descriptor_status_writeback_test;
  // ----------------------------------------------------------------
  // status word flags
  // ----------------------------------------------------------------
  localparam logic [31:0] f_sum = 32'h0000_8000;
  localparam logic [31:0] f_jab = 32'h0000_4000;
  localparam logic [31:0] f_lost = 32'h0000_0800;
  localparam logic [31:0] f_nocar = 32'h0000_0400;
  localparam logic [31:0] f_late = 32'h0000_0200;
  localparam logic [31:0] f_xcol = 32'h0000_0100;
  localparam logic [31:0] f_under = 32'h0000_0002;
  localparam logic [31:0] no_cc = 32'hffff_ff87;
  localparam logic [31:0] all = 32'hffff_ffff;

  logic        clock, rst, awv, wv, bready, arv, rready, car, slow;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        mreq, mwe, mack, go, abort;
  logic [7:0]  aw, ar;
  logic [6:0]  ev;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] wd, rdata, maddr, mwdata, mrdata, d;
  int          bad_count, comparisons;

  txw_writeback #(.ADDR_W(8)) dut (
    .i_clock(clock), .i_rst(rst), .i_s_awvalid(awv), .o_s_awready(awready),
    .i_s_awaddr(aw), .i_s_wvalid(wv), .o_s_wready(wready), .i_s_wdata(wd),
    .i_s_wstrb(4'hf), .o_s_bvalid(bvalid), .i_s_bready(bready), .o_s_bresp(bresp),
    .i_s_arvalid(arv), .o_s_arready(arready), .i_s_araddr(ar), .o_s_rvalid(rvalid),
    .i_s_rready(rready), .o_s_rdata(rdata), .o_s_rresp(rresp), .o_irq(irq),
    .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwdata),
    .i_mem_ack(mack), .i_mem_rdata(mrdata), .o_tx_go(go), .o_tx_abort(abort),
    .i_byte_sent(ev[0]), .i_collision(ev[1]), .i_carrier(car), .i_jabber_expire(ev[2]),
    .i_fifo_empty(ev[3]), .i_heartbeat_fail(ev[4]), .i_buf_done(ev[5]), .i_frame_end(ev[6]));

  txw_host_mem mm (
    .i_clock(clock), .i_rst(rst), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mwdata), .i_slow(slow), .o_ack(mack), .o_rdata(mrdata));

  always #2 clock = ~clock;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("mismatches %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    chk(32'h0, 32'h1);
    complete_run;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge clock);
    awv <= 1'b1;
    aw <= a;
    wv <= 1'b1;
    wd <= v;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awready === 1'b1) awv <= 1'b0;
      if (wready === 1'b1) wv <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 40) hang;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge clock);
    arv <= 1'b1;
    ar <= a;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arready === 1'b1) arv <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) hang;
  endtask

  task automatic pulse(input logic [6:0] v, input int n);
    @(posedge clock);
    ev <= v;
    repeat (n) @(posedge clock);
    ev <= 7'h0;
  endtask

  task automatic start(input logic [1:0] lb);
    int k;
    car <= 1'b0;
    do_reset;
    mm.mem[1] = 32'h0;
    mm.mem[0] = 32'h8000_0000;
    axi_wr(`TXW_OFS_MASK, {26'h0, `TXW_STS_IMPL}, rs);
    axi_wr(`TXW_OFS_MODE, {20'h0, lb, 10'h2}, rs);
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (go === 1'b1) break;
    end
    if (k == 40) hang;
  endtask

  task automatic wb(input logic [31:0] exp, input logic [31:0] msk);
    int k;
    for (k = 0; k < 60; k++) begin
      @(posedge clock);
      if (mreq === 1'b1 && mwe === 1'b1 && mack === 1'b1) break;
    end
    if (k == 60) hang;
    chk(mwdata & msk, exp);
  endtask

  task automatic wait_state(input logic [2:0] st);
    int k;
    for (k = 0; k < 20; k++) begin
      axi_rd(`TXW_OFS_STATUS, d, rs);
      if (d[22:20] === st) break;
    end
    chk({29'h0, d[22:20]}, {29'h0, st});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    do_reset;
    axi_wr(`TXW_OFS_DESC, 32'h0000_0103, rs);
    axi_rd(`TXW_OFS_DESC, d, rs);
    chk(d, 32'h0000_0100);
    axi_wr(8'h14, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, `TXW_RESP_SLVERR});
    axi_rd(8'h14, d, rs);
    chk({d[29:0], rs}, {30'h0, `TXW_RESP_SLVERR});
  endtask

  task automatic t_clean;
    slow <= 1'b1;
    start(2'h0);
    car <= 1'b1;
    pulse(7'h01, 10);
    pulse(7'h40, 1);
    wb(32'h0, all);
    wait_state(3'h5);
    slow <= 1'b0;
  endtask

  task automatic t_jabber;
    start(2'h0);
    pulse(7'h10, 1);
    pulse(7'h04, 1);
    @(posedge clock);
    chk({31'h0, abort}, 32'h1);
    wb(f_jab | f_nocar | f_sum, all);
    chk({31'h0, irq}, 32'h1);
    wait_state(3'h4);
    axi_wr(`TXW_OFS_STATUS, {26'h0, `TXW_STS_IMPL}, rs);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_underrun;
    start(2'h0);
    car <= 1'b1;
    pulse(7'h01, 3);
    pulse(7'h08, 1);
    @(posedge clock);
    chk({31'h0, abort}, 32'h1);
    wb(f_under | f_sum, all);
    wait_state(3'h5);
    chk(d & 32'h29, 32'h21);
    axi_wr(`TXW_OFS_MASK, 32'h0, rs);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_late;
    start(2'h0);
    car <= 1'b1;
    pulse(7'h01, 2);
    car <= 1'b0;
    pulse(7'h01, 62);
    pulse(7'h02, 1);
    wb(f_lost | f_late | f_sum, no_cc);
  endtask

  task automatic t_excess;
    start(2'h0);
    car <= 1'b1;
    pulse(7'h01, 63);
    pulse(7'h02, 16);
    wb(f_xcol | f_sum, no_cc);
  endtask

  task automatic t_loop;
    start(2'h1);
    pulse(7'h01, 4);
    pulse(7'h40, 1);
    wb(32'h0, all);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {awv, wv, bready, arv, rready, car, slow} = 7'h0;
    aw = 8'h0;
    ar = 8'h0;
    wd = 32'h0;
    ev = 7'h0;
    bad_count = 0;
    comparisons = 0;
    t_regs;
    t_clean;
    t_jabber;
    t_underrun;
    t_late;
    t_excess;
    t_loop;
    complete_run;
  end
endmodule

`default_nettype wire
